// ===== rtl/fmd_pkg.sv
// Package with register map, reset values and ramp constants for fan config
package fmd_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_ACOUSTIC2  = 8'h63;
    localparam logic [7:0] ADDR_MIN_DUTY1  = 8'h64;
    localparam logic [7:0] ADDR_MIN_DUTY2  = 8'h65;
    localparam logic [7:0] ADDR_MIN_DUTY3  = 8'h66;
    localparam logic [7:0] ADDR_START_R1   = 8'h67;
    localparam logic [7:0] ADDR_START_LOC  = 8'h68;
    localparam logic [7:0] ADDR_START_R2   = 8'h69;
    // Reset values
    localparam logic [7:0] RST_ACOUSTIC2   = 8'h00;
    localparam logic [7:0] RST_MIN_DUTY    = 8'h80;
    localparam logic [7:0] RST_START_TEMP  = 8'h5A;
    // Field positions in the acoustic register
    localparam int         POS_RATE3       = 0;
    localparam int         POS_EN3         = 3;
    localparam int         POS_RATE2       = 4;
    localparam int         POS_EN2         = 7;
    // Ramp time slot length, in microseconds, and in clock cycles at 25 MHz
    localparam int         CLK_MHZ         = 25;
    localparam int         SLOT_US         = 200000;
    localparam int         SLOT_CYCLES     = SLOT_US * CLK_MHZ;
    // Duty value that stands for full speed
    localparam logic [7:0] DUTY_FULL       = 8'hFF;

    // Code to steps-per-slot decode
    function automatic logic [7:0] fmd_rate_steps(input logic [2:0] code);
        case (code)
            3'h0:    fmd_rate_steps = 8'h01;
            3'h1:    fmd_rate_steps = 8'h02;
            3'h2:    fmd_rate_steps = 8'h03;
            3'h3:    fmd_rate_steps = 8'h05;
            3'h4:    fmd_rate_steps = 8'h08;
            3'h5:    fmd_rate_steps = 8'h0C;
            3'h6:    fmd_rate_steps = 8'h18;
            default: fmd_rate_steps = 8'h30;
        endcase
    endfunction
endpackage

// ===== rtl/fmd_ramp.sv
// Duty ramp for one PWM output: moves toward target by a step each slot
`timescale 1ns/1ps
module fmd_ramp (
    sys_clk,
    reset_n,
    slot_tick,
    ramp_enable,
    ramp_rate,
    target_duty,
    duty_out
);
    input  wire logic       sys_clk;
    input  wire logic       reset_n;
    input  wire logic       slot_tick;
    input  wire logic       ramp_enable;
    input  wire logic [2:0] ramp_rate;
    input  wire logic [7:0] target_duty;
    output logic      [7:0] duty_out;

    typedef struct packed {
        logic [7:0] duty;
    } fmd_ramp_state_t;

    fmd_ramp_state_t state_r;
    fmd_ramp_state_t state_nxt;
    logic [7:0]      step;
    logic [8:0]      up_sum;
    logic [8:0]      dn_dif;

    // Step toward target, clipped so the target is never overshot
    always_comb begin
        state_nxt = state_r;
        step      = fmd_pkg::fmd_rate_steps(ramp_rate);
        up_sum    = {1'b0, state_r.duty} + {1'b0, step};
        dn_dif    = {1'b0, state_r.duty} - {1'b0, step};
        if (!ramp_enable) begin
            state_nxt.duty = target_duty;
        end else if (slot_tick) begin
            if (state_r.duty < target_duty) begin
                if (up_sum[8] || up_sum[7:0] > target_duty) begin
                    state_nxt.duty = target_duty;
                end else begin
                    state_nxt.duty = up_sum[7:0];
                end
            end else if (state_r.duty > target_duty) begin
                if (dn_dif[8] || dn_dif[7:0] < target_duty) begin
                    state_nxt.duty = target_duty;
                end else begin
                    state_nxt.duty = dn_dif[7:0];
                end
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign duty_out = state_r.duty;
endmodule

// ===== rtl/fmd_regs.sv
// Fan minimum duty, start temperature and acoustic ramp register bank
//
// Summary of operation
// - Acoustic bits 6:4 pick output two step size: 1,2,3,5,8,12,24,48.
// - With enable, output two ramps to new duty at selected rate.
// - Bit 3 of acoustic register enables ramping on output three.
// - Bit 7 of acoustic register enables ramping on output two.
// - Acoustic bits 2:0 pick output three step size, same mapping.
// - Acoustic register writes ignored while the global lock bit is set.
// - Three 8-bit minimum duty registers at consecutive addresses.
// - Minimum duty value maps linearly from 0x00 off to 0xFF full.
// - Each minimum duty register resets to 0x80, half duty.
// - Minimum duty registers are read-only in automatic fan mode.
// - Three start temperatures, remote one, local, remote two, reset 0x5A.
// - Above start temperature fan runs from minimum duty rising with span.
// - Start temperature writes ignored while the global lock bit is set.
// - Below start minus hysteresis, duty is zero or minimum per bit.
`timescale 1ns/1ps
module fmd_regs #(
    parameter int SLOT_CYCLES = fmd_pkg::SLOT_CYCLES
) (
    sys_clk,
    reset_n,
    reg_addr,
    reg_wr_en,
    reg_wr_data,
    reg_rd_data,
    config_lock,
    auto_fan_mode,
    calc_duty,
    above_start,
    below_start_hyst,
    below_start_keep_min,
    minimum_duty1,
    minimum_duty2,
    minimum_duty3,
    start_temperature_r1,
    start_temperature_loc,
    start_temperature_r2,
    duty_out1,
    duty_out2,
    duty_out3
);
    input  wire logic        sys_clk;
    input  wire logic        reset_n;
    input  wire logic [7:0]  reg_addr;
    input  wire logic        reg_wr_en;
    input  wire logic [7:0]  reg_wr_data;
    output logic      [7:0]  reg_rd_data;
    input  wire logic        config_lock;
    input  wire logic        auto_fan_mode;
    input  wire logic [23:0] calc_duty;
    input  wire logic [2:0]  above_start;
    input  wire logic [2:0]  below_start_hyst;
    input  wire logic [2:0]  below_start_keep_min;
    output logic      [7:0]  minimum_duty1;
    output logic      [7:0]  minimum_duty2;
    output logic      [7:0]  minimum_duty3;
    output logic      [7:0]  start_temperature_r1;
    output logic      [7:0]  start_temperature_loc;
    output logic      [7:0]  start_temperature_r2;
    output logic      [7:0]  duty_out1;
    output logic      [7:0]  duty_out2;
    output logic      [7:0]  duty_out3;

    if (SLOT_CYCLES < 2) begin : g_chk
        $error("SLOT_CYCLES must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0]  acoustic;
        logic [23:0] min_duty;
        logic [23:0] start_temp;
        logic [7:0]  rd_data;
        logic [31:0] slot_cnt;
        logic        slot_tick;
    } fmd_state_t;

    fmd_state_t  state_r;
    fmd_state_t  state_nxt;
    logic [23:0] target;
    logic [23:0] ramped;

    // Address decode, returns index in a bank of three or 3 for a miss
    function automatic logic [1:0] bank_index(input logic [7:0] a,
                                              input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        bank_index = (d < 8'h03) ? d[1:0] : 2'h3;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes, reads and slot timer
    always_comb begin
        state_nxt = state_r;
        // Slot timer for the ramp
        state_nxt.slot_tick = 1'b0;
        if (state_r.slot_cnt == 32'(SLOT_CYCLES - 1)) begin
            state_nxt.slot_cnt  = '0;
            state_nxt.slot_tick = 1'b1;
        end else begin
            state_nxt.slot_cnt = state_r.slot_cnt + 32'h0000_0001;
        end
        if (reg_wr_en) begin
            if (reg_addr == fmd_pkg::ADDR_ACOUSTIC2 && !config_lock) begin
                state_nxt.acoustic = reg_wr_data;
            end
            if (bank_index(reg_addr, fmd_pkg::ADDR_MIN_DUTY1) != 2'h3 &&
                !auto_fan_mode) begin
                state_nxt.min_duty[bank_index(reg_addr,
                    fmd_pkg::ADDR_MIN_DUTY1)*8 +: 8] = reg_wr_data;
            end
            if (bank_index(reg_addr, fmd_pkg::ADDR_START_R1) != 2'h3 &&
                !config_lock) begin
                state_nxt.start_temp[bank_index(reg_addr,
                    fmd_pkg::ADDR_START_R1)*8 +: 8] = reg_wr_data;
            end
        end
        // read mux over the bank, misses read zero
        state_nxt.rd_data = 8'h00;
        if (reg_addr == fmd_pkg::ADDR_ACOUSTIC2) begin
            state_nxt.rd_data = state_r.acoustic;
        end else if (bank_index(reg_addr, fmd_pkg::ADDR_MIN_DUTY1) != 2'h3) begin
            state_nxt.rd_data = state_r.min_duty[bank_index(reg_addr,
                fmd_pkg::ADDR_MIN_DUTY1)*8 +: 8];
        end else if (bank_index(reg_addr, fmd_pkg::ADDR_START_R1) != 2'h3) begin
            state_nxt.rd_data = state_r.start_temp[bank_index(reg_addr,
                fmd_pkg::ADDR_START_R1)*8 +: 8];
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r.acoustic   <= fmd_pkg::RST_ACOUSTIC2;
            state_r.min_duty   <= {3{fmd_pkg::RST_MIN_DUTY}};
            state_r.start_temp <= {3{fmd_pkg::RST_START_TEMP}};
            state_r.rd_data    <= 8'h00;
            state_r.slot_cnt   <= '0;
            state_r.slot_tick  <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target duty per output and ramps
    genvar i;
    for (i = 0; i < 3; i++) begin : g_out
        // minimum duty floor above start temperature
        // below start choose off or minimum
        always_comb begin
            if (!auto_fan_mode) begin
                target[i*8 +: 8] = calc_duty[i*8 +: 8];
            end else if (below_start_hyst[i]) begin
                target[i*8 +: 8] = below_start_keep_min[i] ?
                    state_r.min_duty[i*8 +: 8] : 8'h00;
            end else if (above_start[i] &&
                         calc_duty[i*8 +: 8] < state_r.min_duty[i*8 +: 8]) begin
                target[i*8 +: 8] = state_r.min_duty[i*8 +: 8];
            end else begin
                target[i*8 +: 8] = calc_duty[i*8 +: 8];
            end
        end
    end

    // Output one has no ramp; it follows its target through a flop
    fmd_ramp u_ramp1 (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .slot_tick   (state_r.slot_tick),
        .ramp_enable (1'b0),
        .ramp_rate   (3'h0),
        .target_duty (target[7:0]),
        .duty_out    (ramped[7:0])
    );

    fmd_ramp u_ramp2 (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .slot_tick   (state_r.slot_tick),
        .ramp_enable (state_r.acoustic[fmd_pkg::POS_EN2]),
        .ramp_rate   (state_r.acoustic[fmd_pkg::POS_RATE2 +: 3]),
        .target_duty (target[15:8]),
        .duty_out    (ramped[15:8])
    );

    fmd_ramp u_ramp3 (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .slot_tick   (state_r.slot_tick),
        .ramp_enable (state_r.acoustic[fmd_pkg::POS_EN3]),
        .ramp_rate   (state_r.acoustic[fmd_pkg::POS_RATE3 +: 3]),
        .target_duty (target[23:16]),
        .duty_out    (ramped[23:16])
    );

    // Outputs
    assign reg_rd_data           = state_r.rd_data;
    assign minimum_duty1         = state_r.min_duty[7:0];
    assign minimum_duty2         = state_r.min_duty[15:8];
    assign minimum_duty3         = state_r.min_duty[23:16];
    assign start_temperature_r1  = state_r.start_temp[7:0];
    assign start_temperature_loc = state_r.start_temp[15:8];
    assign start_temperature_r2  = state_r.start_temp[23:16];
    assign duty_out1             = ramped[7:0];
    assign duty_out2             = ramped[15:8];
    assign duty_out3             = ramped[23:16];
endmodule

// ===== verification/fmd_regs_properties.sv
// Port assertions for the fan configuration register bank
`timescale 1ns/1ps
module fmd_regs_properties #(
    parameter int SLOT_CYCLES = 4
) (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr_en,
    input wire logic [7:0]  reg_wr_data,
    input wire logic [7:0]  reg_rd_data,
    input wire logic        config_lock,
    input wire logic        auto_fan_mode,
    input wire logic [23:0] calc_duty,
    input wire logic [2:0]  above_start,
    input wire logic [2:0]  below_start_hyst,
    input wire logic [2:0]  below_start_keep_min,
    input wire logic [7:0]  minimum_duty1,
    input wire logic [7:0]  minimum_duty2,
    input wire logic [7:0]  start_temperature_r1,
    input wire logic [7:0]  start_temperature_r2,
    input wire logic [7:0]  duty_out1
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_start_lock_hold: assert property (reg_wr_en && config_lock
        && reg_addr == 8'h67 |=> $stable(start_temperature_r1))
        else $error("start temperature written under lock");
    a_start_write: assert property (reg_wr_en && !config_lock
        && reg_addr == 8'h69 |=> start_temperature_r2 == $past(reg_wr_data))
        else $error("start temperature write lost");
    a_min_auto_hold: assert property (reg_wr_en && auto_fan_mode
        && reg_addr == 8'h64 |=> $stable(minimum_duty1))
        else $error("minimum duty written in auto mode");
    a_min_write: assert property (reg_wr_en && !auto_fan_mode
        && reg_addr == 8'h64 |=> minimum_duty1 == $past(reg_wr_data))
        else $error("minimum duty write lost");
    a_rd_unmapped: assert property ((reg_addr < 8'h63
        || reg_addr > 8'h69) |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_rd_min_two: assert property (!reg_wr_en
        && reg_addr == 8'h65 |=> reg_rd_data == minimum_duty2)
        else $error("read data differs from register");
    a_out_manual: assert property (!auto_fan_mode
        |=> duty_out1 == $past(calc_duty[7:0]))
        else $error("manual duty not followed");
    a_out_off: assert property (auto_fan_mode && below_start_hyst[0]
        && !below_start_keep_min[0] |=> duty_out1 == 8'h00)
        else $error("output not off below start");
    a_out_floor: assert property (auto_fan_mode && !below_start_hyst[0]
        && above_start[0] && calc_duty[7:0] < minimum_duty1
        |=> duty_out1 == $past(minimum_duty1))
        else $error("output below minimum duty");
endmodule

bind fmd_regs fmd_regs_properties #(.SLOT_CYCLES(SLOT_CYCLES)) u_props (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .config_lock(config_lock),
    .auto_fan_mode(auto_fan_mode), .calc_duty(calc_duty),
    .above_start(above_start), .below_start_hyst(below_start_hyst),
    .below_start_keep_min(below_start_keep_min),
    .minimum_duty1(minimum_duty1), .minimum_duty2(minimum_duty2),
    .start_temperature_r1(start_temperature_r1),
    .start_temperature_r2(start_temperature_r2), .duty_out1(duty_out1));

// ===== verification/fmd_regs_tb.sv
// Self-checking bench for the fan configuration register bank
`timescale 1ns/1ps
module fmd_regs_tb;
    localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                         8'h08, 8'h0C, 8'h18, 8'h30};
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr_en = 1'b0;
    logic [7:0]  reg_wr_data = 8'h00;
    logic [7:0]  reg_rd_data;
    logic        config_lock = 1'b0;
    logic        auto_fan_mode = 1'b0;
    logic [23:0] calc_duty = 24'h00_0000;
    logic [2:0]  hy = 3'h0, kp = 3'h0, ab = 3'h0;
    logic [7:0]  dout [3];
    logic [7:0]  ro [6];
    logic [7:0]  ev [7];
    logic [7:0]  d, e, p;
    int          checks = 0, miscompares = 0, t;

    fmd_regs #(.SLOT_CYCLES(4)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .config_lock(config_lock),
        .auto_fan_mode(auto_fan_mode), .calc_duty(calc_duty),
        .above_start(ab), .below_start_hyst(hy),
        .below_start_keep_min(kp), .minimum_duty1(ro[0]),
        .minimum_duty2(ro[1]), .minimum_duty3(ro[2]),
        .start_temperature_r1(ro[3]), .start_temperature_loc(ro[4]),
        .start_temperature_r2(ro[5]),
        .duty_out1(dout[0]), .duty_out2(dout[1]), .duty_out3(dout[2]));

    always #20 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, dv);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wr_data = dv;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        chk("read", reg_rd_data, exp);
    endtask
    // Automatic mode target for one output
    function automatic logic [7:0] tgt(input logic h, k, b,
                                       input logic [7:0] c, m);
        if (h) return k ? m : 8'h00;
        if (b && c < m) return m;
        return c;
    endfunction
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        miscompares++;
        summarize();
    end

    initial begin
        void'($urandom(70304));
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        // reset values, then random write and read back
        ev = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A};
        for (int i = 0; i < 7; i++) begin
            rd(8'h63 + 8'(i), ev[i]);
            if (i > 0) chk("reset port", ro[i-1], ev[i]);
            d = 8'($urandom);
            wr(8'h63 + 8'(i), d);
            ev[i] = d;
            rd(8'h63 + 8'(i), d);
            if (i > 0) chk("register port", ro[i-1], d);
        end
        wr(8'h6A, 8'h5A);
        rd(8'h6A, 8'h00);
        $display("registers done");
        // lock and automatic mode block their registers
        for (int m = 0; m < 2; m++) begin
            config_lock = (m == 0);
            auto_fan_mode = (m == 1);
            for (int i = 0; i < 7; i++) begin
                d = ~ev[i];
                wr(8'h63 + 8'(i), d);
                if ((i >= 1 && i <= 3) != (m == 1)) ev[i] = d;
                rd(8'h63 + 8'(i), ev[i]);
                if (i > 0) chk("blocked port", ro[i-1], ev[i]);
            end
        end
        $display("blocking done");
        config_lock = 1'b0;
        auto_fan_mode = 1'b0;
        wr(8'h63, 8'h00);
        auto_fan_mode = 1'b1;
        // duty target in both modes, no ramping
        for (int n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            {hy, kp, ab} = 9'($urandom);
            calc_duty = 24'($urandom);
            if (n > 0) auto_fan_mode = 1'($urandom);
            if (n == 0) {hy, ab} = 6'h07;
            if (n == 0) calc_duty = {ev[3] - 8'h01, ev[2] - 8'h01,
                                     ev[1] - 8'h01};
            @(negedge sys_clk);
            for (int j = 0; j < 3; j++) begin
                e = calc_duty[8*j+:8];
                if (auto_fan_mode) e = tgt(hy[j], kp[j], ab[j], e, ev[j+1]);
                chk("duty", dout[j], e);
            end
        end
        $display("targets done");
        auto_fan_mode = 1'b0;
        // every ramp code, output three on upper half
        for (int c = 0; c < 16; c++) begin
            calc_duty = 24'h00_0000;
            wr(8'h63, 8'h00);
            wr(8'h63, {1'b1, 3'(c), c[3], 3'(c)});
            calc_duty = 24'hC0_C000;
            for (int n = 1; n <= 4; n++) begin
                // Turn round after two slots, down to a target of one
                if (n == 3) calc_duty = 24'h01_0100;
                p = dout[1];
                t = 0;
                while (dout[1] === p && t < 20) begin
                    @(negedge sys_clk);
                    t++;
                end
                e = (n < 3) ? 8'(STEPS[c[2:0]] * n) :
                    (n == 3) ? STEPS[c[2:0]] : 8'h01;
                chk("ramp two", dout[1], e);
                chk("ramp three", dout[2], c[3] ? e : calc_duty[23:16]);
            end
        end
        $display("ramps done");
        summarize();
    end
endmodule
